/* File: verilog/pmap_pkg.sv */
// package: constants for boot-mode selection and program-space decoding
// assumes: word-addressed 21-bit program space
package pmap_pkg;
  localparam int          PADDR_W          = 21;
  localparam int          EXT_W16          = 16;
  localparam int          EXT_W20          = 20;
  localparam logic [20:0] BOOT_BASE_LO     = 21'h000000;
  localparam logic [20:0] BOOT_BASE_HI     = 21'h020000;
  localparam logic [20:0] WDOG_OFFSET      = 21'h000002;
  localparam logic [20:0] BANK_64K_MASK    = 21'h1F0000;
  localparam logic [20:0] BANK0_BASE       = 21'h000000;
  localparam logic [20:0] BANK1_BASE       = 21'h010000;
  localparam logic [20:0] BOOTFL_BASE      = 21'h020000;
  localparam logic [20:0] BOOTFL_END       = 21'h020FFF;
  localparam logic [20:0] PRAM_BASE        = 21'h02F800;
  localparam logic [20:0] PRAM_END         = 21'h02FFFF;
  localparam logic [20:0] EXT_HI_BASE      = 21'h100000;
  localparam logic [20:0] RESET_REACH_END  = 21'h00FFFF;
  localparam logic [3:0]  UPPER_ADDR_USED  = 4'h1;
  localparam logic        SEC_BIT_RST      = 1'b0;
  localparam logic        BOOT_BIT_RST     = 1'b0;

  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_IFLASH,
    TGT_BOOTFL,
    TGT_PRAM,
    TGT_EXT
  } target_e;
endpackage

/* File: verilog/mode_if.sv */
// interface: latched mode state from the mode latch to the decoder
// assumes: single clock domain
`timescale 1ns/1ps
`default_nettype none
interface mode_if;
  logic boot_sel;
  logic ext_boot;
  logic wide_bus;
  logic secured;
  modport latch (output boot_sel, output ext_boot, output wide_bus, output secured);
  modport dec   (input boot_sel, input ext_boot, input wide_bus, input secured);
endinterface
`default_nettype wire

/* File: verilog/mode_latch.sv */
// module: captures mode bits at reset and holds the boot-select write path
// assumes: pins synchronous to mclk, reset held at least one edge
`timescale 1ns/1ps
`default_nettype none
module mode_latch
  import pmap_pkg::*;
(
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic flash_secure_n,
  input  wire logic external_boot_pin,
  input  wire logic address_width_pin,
  input  wire logic boot_bit_wr,
  input  wire logic boot_bit_wdata,
  input  wire logic sec_bit_wr,
  input  wire logic sec_bit_wdata,
  mode_if.latch     m,
  output logic      secure_state_bit,
  output logic      boot_select_bit
);
  logic sec_ff;
  logic sec_sw_ff;
  logic boot_ff;
  logic wide_ff;
  logic ext_ff;

  // sampled every reset cycle, frozen from release
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sec_ff  <= flash_secure_n;                                      // [RULE1] [RULE5] [RULE16]
      ext_ff  <= flash_secure_n & external_boot_pin;                  // [RULE3] [RULE4]
      wide_ff <= flash_secure_n & external_boot_pin & address_width_pin; // [RULE2] [RULE9]
    end
  end

  // software copy of the secure bit; no effect on security or map
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sec_sw_ff <= flash_secure_n;
    end else if (clk_en && sec_bit_wr) begin
      sec_sw_ff <= sec_bit_wdata;                                     // [RULE6]
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      boot_ff <= flash_secure_n & external_boot_pin;                  // [RULE1] [RULE3]
    end else if (clk_en && boot_bit_wr && sec_ff) begin
      boot_ff <= boot_bit_wdata;                                      // [RULE7]
    end
  end

  assign m.boot_sel        = boot_ff;
  assign m.ext_boot        = ext_ff;
  assign m.wide_bus        = wide_ff;
  assign m.secured         = ~sec_ff;
  assign secure_state_bit  = sec_sw_ff;
  assign boot_select_bit   = boot_ff;
endmodule
`default_nettype wire

/* File: verilog/addr_decode.sv */
// module: combinational program-space target decode
// assumes: mode inputs stable after reset
`timescale 1ns/1ps
`default_nettype none
module addr_decode
  import pmap_pkg::*;
(
  input  wire logic [PADDR_W-1:0] paddr,
  mode_if.dec                     m,
  output target_e                 target,
  output logic    [PADDR_W-1:0]   local_addr
);
  logic [PADDR_W-1:0] bank;

  always_comb begin
    bank       = paddr & BANK_64K_MASK;
    target     = TGT_NONE;
    local_addr = paddr;
    if (paddr >= PRAM_BASE && paddr <= PRAM_END) begin
      target     = TGT_PRAM;
      local_addr = paddr - PRAM_BASE;
    end else if (paddr >= BOOTFL_BASE && paddr <= BOOTFL_END) begin
      if (m.boot_sel && m.wide_bus) begin
        target = TGT_EXT;                                             // [RULE12]
      end else begin
        target     = TGT_BOOTFL;                                      // [RULE10] [RULE11]
        local_addr = paddr - BOOTFL_BASE;
      end
    end else if (bank == BANK0_BASE || bank == BANK1_BASE) begin
      if (m.boot_sel && !m.wide_bus) begin
        target     = (bank == BANK0_BASE) ? TGT_EXT : TGT_IFLASH;     // [RULE11]
        local_addr = paddr - bank;
      end else begin
        target = (bank == BANK0_BASE) ? TGT_IFLASH : TGT_EXT;         // [RULE10]
      end
    end else if (paddr >= EXT_HI_BASE) begin
      target = TGT_EXT;
    end
    // no external program space while secured
    if (m.secured && (target == TGT_EXT)) begin
      target = TGT_NONE;                                              // [RULE2]
    end
  end
endmodule
`default_nettype wire

/* File: verilog/program_map_boot_mode_select.sv */
// top: boot-mode selection and program-space address routing
// assumes: core issues one program access per cycle; pins synchronous to mclk
// Overview of operation
// RULE1: reset loads secure bit and external-boot bit
// RULE2: mode 00: internal boot, secured, debug off
// RULE3: secured plus external request acts as 00
// RULE4: unsecured external boot: width follows pin
// RULE5: secure bit captured only at reset
// RULE6: writing secure bit changes nothing else
// RULE7: boot bit writable unless secured at reset
// RULE8: first chip-selects act as program/data strobes
// RULE9: width pin high enables upper address A16
// RULE10: internal boot: flash, ext RAM, boot flash
// RULE11: external 16-bit: ext RAM low, flash relocated
// RULE12: external 20-bit: ext RAM replaces boot flash
// RULE13: software reconfigures pins above 00FFFF
// RULE14: data flash read by one bus only
// RULE15: board ties boot pin per security
// RULE16: mode sampled in reset, stable after
`timescale 1ns/1ps
`default_nettype none
module program_map_boot_mode_select
  import pmap_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  input  wire logic               clk_en,
  input  wire logic               flash_secure_n,
  input  wire logic               external_boot_pin,
  input  wire logic               address_width_pin,
  input  wire logic               boot_bit_wr,
  input  wire logic               boot_bit_wdata,
  input  wire logic               sec_bit_wr,
  input  wire logic               sec_bit_wdata,
  input  wire logic               pfetch_req,
  input  wire logic [PADDR_W-1:0] pfetch_addr,
  input  wire logic               upper_pins_cfg,
  input  wire logic               dflash_rd_core,
  input  wire logic               dflash_rd_sec,
  output logic                    secure_state_ff,
  output logic                    boot_select_ff,
  output logic                    ext_bus_wide_ff,
  output logic                    debug_enable_ff,
  output logic                    ext_pspace_allow_ff,
  output logic [PADDR_W-1:0]      reset_vector_ff,
  output logic [PADDR_W-1:0]      watchdog_vector_ff,
  output logic [3:0]              upper_addr_en_ff,
  output logic                    program_space_strobe_ff,
  output logic                    data_space_strobe_ff,
  output logic                    sel_iflash_ff,
  output logic                    sel_bootfl_ff,
  output logic                    sel_pram_ff,
  output logic                    sel_ext_ff,
  output logic                    access_fault_ff,
  output logic [PADDR_W-1:0]      local_addr_ff,
  output logic                    dflash_grant_core_ff,
  output logic                    dflash_grant_sec_ff
);
  mode_if  mif ();
  target_e tgt;
  logic [PADDR_W-1:0] loc;
  logic               sec_sw;
  logic               boot_sw;
  logic               ext_ok;

  mode_latch u_latch (
    .mclk              (mclk),
    .sys_rst           (sys_rst),
    .clk_en            (clk_en),
    .flash_secure_n    (flash_secure_n),
    .external_boot_pin (external_boot_pin),
    .address_width_pin (address_width_pin),
    .boot_bit_wr       (boot_bit_wr),
    .boot_bit_wdata    (boot_bit_wdata),
    .sec_bit_wr        (sec_bit_wr),
    .sec_bit_wdata     (sec_bit_wdata),
    .m                 (mif.latch),
    .secure_state_bit  (sec_sw),
    .boot_select_bit   (boot_sw)
  );

  addr_decode u_dec (
    .paddr      (pfetch_addr),
    .m          (mif.dec),
    .target     (tgt),
    .local_addr (loc)
  );

  // addresses above 00FFFF need pins reconfigured first; wide-bus boot region is reachable
  assign ext_ok = (pfetch_addr <= RESET_REACH_END) || upper_pins_cfg ||   // [RULE13]
                  (mif.wide_bus && (pfetch_addr >= BOOTFL_BASE) &&
                   (pfetch_addr <= BOOTFL_END));                          // [RULE12]

  // mode-derived configuration outputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      secure_state_ff     <= SEC_BIT_RST;
      boot_select_ff      <= BOOT_BIT_RST;
      ext_bus_wide_ff     <= 1'b0;
      debug_enable_ff     <= 1'b0;
      ext_pspace_allow_ff <= 1'b0;
      upper_addr_en_ff    <= 4'h0;
    end else if (clk_en) begin
      secure_state_ff     <= sec_sw;
      boot_select_ff      <= boot_sw;
      ext_bus_wide_ff     <= mif.wide_bus;                            // [RULE4]
      debug_enable_ff     <= ~mif.secured;                            // [RULE2]
      ext_pspace_allow_ff <= ~mif.secured;                            // [RULE2]
      upper_addr_en_ff    <= mif.wide_bus ? UPPER_ADDR_USED : 4'h0;   // [RULE9]
    end
  end

  // reset and watchdog vectors
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reset_vector_ff    <= BOOT_BASE_HI;
      watchdog_vector_ff <= BOOT_BASE_HI + WDOG_OFFSET;
    end else if (clk_en) begin
      if (mif.ext_boot && !mif.wide_bus) begin
        reset_vector_ff    <= BOOT_BASE_LO;                           // [RULE11]
        watchdog_vector_ff <= BOOT_BASE_LO + WDOG_OFFSET;
      end else begin
        reset_vector_ff    <= BOOT_BASE_HI;                           // [RULE10] [RULE12]
        watchdog_vector_ff <= BOOT_BASE_HI + WDOG_OFFSET;
      end
    end
  end

  // legacy strobes from the first two chip selects
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      program_space_strobe_ff <= 1'b0;
      data_space_strobe_ff    <= 1'b0;
    end else if (clk_en) begin
      program_space_strobe_ff <= pfetch_req && (tgt == TGT_EXT) && ext_ok; // [RULE8]
      data_space_strobe_ff    <= dflash_rd_sec && !dflash_rd_core;   // [RULE8]
    end
  end

  // program-space routing
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sel_iflash_ff   <= 1'b0;
      sel_bootfl_ff   <= 1'b0;
      sel_pram_ff     <= 1'b0;
      sel_ext_ff      <= 1'b0;
      access_fault_ff <= 1'b0;
      local_addr_ff   <= '0;
    end else if (clk_en) begin
      sel_iflash_ff   <= pfetch_req && (tgt == TGT_IFLASH);            // [RULE10]
      sel_bootfl_ff   <= pfetch_req && (tgt == TGT_BOOTFL);
      sel_pram_ff     <= pfetch_req && (tgt == TGT_PRAM);
      sel_ext_ff      <= pfetch_req && (tgt == TGT_EXT) && ext_ok;     // [RULE13]
      access_fault_ff <= pfetch_req && ((tgt == TGT_NONE) ||
                         ((tgt == TGT_EXT) && !ext_ok));
      local_addr_ff   <= loc;
    end
  end

  // data flash read port: one bus per cycle, core wins
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dflash_grant_core_ff <= 1'b0;
      dflash_grant_sec_ff  <= 1'b0;
    end else if (clk_en) begin
      dflash_grant_core_ff <= dflash_rd_core;                          // [RULE14]
      dflash_grant_sec_ff  <= dflash_rd_sec && !dflash_rd_core;        // [RULE14]
    end
  end
endmodule
`default_nettype wire

/* File: testbench/core_model.sv */
// model: processor core issuing program fetches
// assumes: design samples requests on the rising edge of mclk
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic        mclk,
  output var  logic        pfetch_req,
  output var  logic [20:0] pfetch_addr,
  output var  logic        upper_pins_cfg
);
  initial begin
    pfetch_req = 1'b0;
    pfetch_addr = 21'h000000;
    upper_pins_cfg = 1'b0;
  end
  // one fetch, held for one edge, then address scrambled
  task automatic fetch(input logic [20:0] a, input logic cfg);
    @(negedge mclk);
    upper_pins_cfg = cfg;
    pfetch_req = 1'b1;
    pfetch_addr = a;
    @(negedge mclk);
    pfetch_req = 1'b0;
    pfetch_addr = ~a;
  endtask
endmodule
`default_nettype wire

/* File: testbench/pmap_assertions.sv */
// checker: mode and decode relations at the top ports
// assumes: bound to the top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module pmap_assertions (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  input wire logic        pfetch_req,
  input wire logic        sec_bit_wr,
  input wire logic        sec_bit_wdata,
  input wire logic        dflash_rd_core,
  input wire logic        dflash_rd_sec,
  input wire logic        secure_state_ff,
  input wire logic        ext_bus_wide_ff,
  input wire logic        debug_enable_ff,
  input wire logic [20:0] reset_vector_ff,
  input wire logic [20:0] watchdog_vector_ff,
  input wire logic [3:0]  upper_addr_en_ff,
  input wire logic        sel_iflash_ff,
  input wire logic        sel_bootfl_ff,
  input wire logic        sel_pram_ff,
  input wire logic        sel_ext_ff,
  input wire logic        access_fault_ff,
  input wire logic        dflash_grant_core_ff,
  input wire logic        dflash_grant_sec_ff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_upper; upper_addr_en_ff == (ext_bus_wide_ff ? 4'h1 : 4'h0); endproperty
  a_upper: assert property (p_upper)
    else $error("upper address enables wrong");
  property p_wide; ext_bus_wide_ff |-> debug_enable_ff; endproperty
  a_wide: assert property (p_wide)
    else $error("wide bus while secured");
  property p_vec; watchdog_vector_ff == reset_vector_ff + 21'h000002; endproperty
  a_vec: assert property (p_vec)
    else $error("watchdog vector not boot plus two");
  property p_fetch; pfetch_req && clk_en |-> ##[1:2] $onehot({sel_iflash_ff,
    sel_bootfl_ff, sel_pram_ff, sel_ext_ff, access_fault_ff}); endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch without single target");
  property p_dfl; dflash_rd_core && dflash_rd_sec && clk_en |-> ##[1:2] dflash_grant_core_ff;
  endproperty
  a_dfl: assert property (p_dfl)
    else $error("core read not granted");
  property p_excl; !(dflash_grant_core_ff && dflash_grant_sec_ff); endproperty
  a_excl: assert property (p_excl)
    else $error("both data flash grants");
  property p_hold; !$past(sys_rst) && !$past(sys_rst, 2) |->
    $stable({ext_bus_wide_ff, debug_enable_ff, reset_vector_ff}); endproperty
  a_hold: assert property (p_hold)
    else $error("mode changed after reset");
  property p_secwr; sec_bit_wr && clk_en |-> ##2 secure_state_ff == $past(sec_bit_wdata, 2);
  endproperty
  a_secwr: assert property (p_secwr)
    else $error("secure bit write lost");
endmodule
`default_nettype wire

/* File: testbench/test_program_map_boot_mode_select.sv */
// testbench: boots each mode, fetches, writes mode bits, judges outputs
// assumes: package, design, model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module test_program_map_boot_mode_select;
  import pmap_pkg::*;
  logic mclk = 0, sys_rst = 1, clk_en = 1, flash_secure_n = 0, external_boot_pin = 0;
  logic address_width_pin = 0, boot_bit_wr = 0, boot_bit_wdata = 0, sec_bit_wr = 0;
  logic sec_bit_wdata = 0, dflash_rd_core = 0, dflash_rd_sec = 0, pfetch_req, upper_pins_cfg;
  logic secure_state_ff, boot_select_ff, ext_bus_wide_ff, debug_enable_ff, ext_pspace_allow_ff;
  logic program_space_strobe_ff, data_space_strobe_ff, access_fault_ff, sel_iflash_ff;
  logic sel_bootfl_ff, sel_pram_ff, sel_ext_ff, dflash_grant_core_ff, dflash_grant_sec_ff;
  logic [3:0] upper_addr_en_ff;
  logic [20:0] reset_vector_ff, watchdog_vector_ff, local_addr_ff, pfetch_addr;
  int n_errors = 0, checked = 0, cyc = 0;
  program_map_boot_mode_select DUT (.*);
  core_model u_core (.mclk(mclk), .pfetch_req(pfetch_req), .pfetch_addr(pfetch_addr),
    .upper_pins_cfg(upper_pins_cfg));
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic boot(input logic s, input logic b, input logic w);
    @(negedge mclk);
    sys_rst = 1'b1;
    flash_secure_n = s;
    external_boot_pin = b;
    address_width_pin = w;
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic vec(input logic [20:0] v);
    chk(reset_vector_ff, v);
    chk(watchdog_vector_ff, v + 21'h000002);
  endtask
  // target code: iflash, boot flash, pram, external, fault
  task automatic fetch(input logic [20:0] a, input logic c, input logic [4:0] t,
                       input logic [20:0] loc);
    logic [4:0]  seen;
    logic [20:0] la;
    logic        strobe;
    seen = 5'h00;
    la = 21'h000000;
    strobe = 1'b0;
    u_core.fetch(a, c);
    repeat (2) begin
      if ({sel_iflash_ff, sel_bootfl_ff, sel_pram_ff, sel_ext_ff, access_fault_ff} != 0) begin
        seen = {sel_iflash_ff, sel_bootfl_ff, sel_pram_ff, sel_ext_ff, access_fault_ff};
        la = local_addr_ff;
        strobe = program_space_strobe_ff;
      end
      @(negedge mclk);
    end
    chk(seen, t);
    if (t != 5'h01) chk(la, loc);
    chk(strobe, t == 5'h02);
  endtask
  task automatic wr(input logic sec, input logic d);
    @(negedge mclk);
    {boot_bit_wr, boot_bit_wdata, sec_bit_wr, sec_bit_wdata} = {~sec, d, sec, d};
    @(negedge mclk);
    {boot_bit_wr, sec_bit_wr} = 2'h0;
    repeat (3) @(negedge mclk);
  endtask
  task automatic t_mode0();
    logic [1:0] g;
    boot(1'b0, 1'b0, 1'b0);
    chk({secure_state_ff, boot_select_ff}, 2'h0);
    chk({debug_enable_ff, ext_pspace_allow_ff, ext_bus_wide_ff}, 3'h0);
    vec(21'h020000);
    fetch(21'h000123, 1'b0, 5'h10, 21'h000123);
    fetch(21'h020004, 1'b0, 5'h08, 21'h000004);
    fetch(21'h02F801, 1'b0, 5'h04, 21'h000001);
    fetch(21'h010000, 1'b0, 5'h01, 21'h000000);
    {dflash_rd_core, dflash_rd_sec} = 2'h3;
    @(negedge mclk);
    {dflash_rd_core, dflash_rd_sec} = 2'h0;
    g = {dflash_grant_core_ff, dflash_grant_sec_ff};
    @(negedge mclk);
    g = g | {dflash_grant_core_ff, dflash_grant_sec_ff};
    chk(g, 2'h2);
    {dflash_rd_core, dflash_rd_sec} = 2'h1;
    @(negedge mclk);
    {dflash_rd_core, dflash_rd_sec} = 2'h0;
    chk({dflash_grant_core_ff, dflash_grant_sec_ff, data_space_strobe_ff}, 3'h3);
    clk_en = 1'b0;
    fetch(21'h000123, 1'b0, 5'h00, 21'h000000);
    clk_en = 1'b1;
    $display("mode 0 test done");
  endtask
  task automatic t_secured();
    boot(1'b0, 1'b1, 1'b1);
    chk({boot_select_ff, ext_bus_wide_ff, upper_addr_en_ff}, 6'h00);
    vec(21'h020000);
    wr(1'b0, 1'b1);
    chk(boot_select_ff, 1'b0);
    fetch(21'h000010, 1'b0, 5'h10, 21'h000010);
    $display("secured test done");
  endtask
  task automatic t_unsec_int();
    boot(1'b1, 1'b0, 1'b1);
    chk({secure_state_ff, boot_select_ff, ext_bus_wide_ff, debug_enable_ff}, 4'h9);
    vec(21'h020000);
    wr(1'b0, 1'b1);
    chk(boot_select_ff, 1'b1);
    fetch(21'h000010, 1'b0, 5'h02, 21'h000010);
    $display("unsecured internal test done");
  endtask
  task automatic t_ext16();
    boot(1'b1, 1'b1, 1'b0);
    chk({secure_state_ff, boot_select_ff, ext_bus_wide_ff}, 3'h6);
    vec(21'h000000);
    fetch(21'h000010, 1'b0, 5'h02, 21'h000010);
    fetch(21'h010005, 1'b0, 5'h10, 21'h000005);
    wr(1'b0, 1'b0);
    chk(boot_select_ff, 1'b0);
    fetch(21'h000010, 1'b0, 5'h10, 21'h000010);
    $display("external 16 test done");
  endtask
  task automatic t_ext20();
    boot(1'b1, 1'b1, 1'b1);
    chk({ext_bus_wide_ff, upper_addr_en_ff, debug_enable_ff}, 6'h23);
    vec(21'h020000);
    fetch(21'h020000, 1'b0, 5'h02, 21'h020000);
    fetch(21'h100000, 1'b1, 5'h02, 21'h100000);
    flash_secure_n = 1'b0;
    repeat (3) @(negedge mclk);
    chk(secure_state_ff, 1'b1);
    wr(1'b1, 1'b0);
    chk({secure_state_ff, debug_enable_ff, ext_bus_wide_ff}, 3'h3);
    $display("external 20 test done");
  endtask
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    t_mode0();
    t_secured();
    t_unsec_int();
    t_ext16();
    t_ext20();
    results();
  end
endmodule
bind program_map_boot_mode_select pmap_assertions u_chk (.*);
`default_nettype wire
